/* dv/ccs_far_model.sv */
// far side model: interrupt vector unit and timer capture counter
// assumes its inputs are synchronous to clk
`timescale 1ns/100ps
module ccs_far_model (
	input wire logic clk, // system clock
	input wire logic [2:0] vec_go, // vector commanded per cmp
	input wire logic cap_irq, // capture irq request
	output logic [2:0] irq_ack, // vector executed
	output int cap_count // capture interrupts taken
);
	// vector runs one cycle after it is commanded
	always_ff @(posedge clk) begin
		irq_ack <= vec_go;
	end
	// timer only takes a capture irq its mask let through
	always_ff @(posedge clk) begin
		cap_count <= cap_count + (cap_irq ? 1 : 0);
	end
endmodule

/* dv/tb_top.sv */
// testbench of the comparator register bank
// assumes an ahb-lite slave that never waits and the far side model
`timescale 1ns/100ps
module tb_top;
	import ccs_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] cmp_raw = 3'h0;
	logic [2:0] vec_go = 3'h0;
	logic edge_sel = 1'b1;
	logic cap_mask = 1'b0;
	logic [15:0] pin_raw = 16'hffff;
	logic hready, hreadyout, hresp, cap_input, cap_event, cap_irq_req, irq;
	logic [31:0] hrdata, rd_data;
	logic [2:0][2:0] neg_sel, hyst;
	logic [2:0] pin_out, pin_oe, live, flags, irq_req, irq_ack;
	logic [15:0] pin_dis, pin_gated;
	logic [2:0] h;
	int cap_count, c0;
	int n_fail = 0;
	int comparisons = 0;

	// clock and the single slave's ready
	initial forever #10 clk = ~clk;
	assign hready = hreadyout;

	// design and far side
	ccs_comparator_regs i_ccs_comparator_regs (.clk(clk), .srst(srst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.cmp_raw(cmp_raw), .irq_ack(irq_ack),
		.timer_capture_edge_select(edge_sel),
		.timer_capture_irq_mask(cap_mask), .pin_raw(pin_raw),
		.cmp_neg_select(neg_sel), .cmp_hysteresis(hyst),
		.cmp_pin_out(pin_out), .cmp_pin_oe(pin_oe),
		.cmp_live_output(live), .cmp_event_flag(flags),
		.cmp_irq_req(irq_req), .cap_input(cap_input),
		.cap_event(cap_event), .cap_irq_req(cap_irq_req),
		.pin_in_disable(pin_dis), .pin_in_gated(pin_gated), .irq(irq));
	ccs_far_model i_ccs_far_model (.clk(clk), .vec_go(vec_go),
		.cap_irq(cap_irq_req), .irq_ack(irq_ack), .cap_count(cap_count));

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one ahb single transfer, settled after its last edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge clk); while (hready !== 1'b1);
		rd_data = hrdata;
		hsel <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rd_data, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic raw(input int i, input logic v);
		@(posedge clk);
		cmp_raw[i] <= v;
		tick(4);
	endtask
	task automatic tim(input logic es, input logic m);
		@(posedge clk);
		edge_sel <= es;
		cap_mask <= m;
	endtask
	task automatic ack1;
		@(posedge clk);
		vec_go <= 3'h2;
		@(posedge clk);
		vec_go <= 3'h0;
		tick(2);
	endtask
	// every register and some unmapped words read zero
	task automatic t_reset;
		for (int a = 0; a <= 48; a += 4) begin
			rd(8'(a), 32'h0000_0000);
		end
		chk(32'(pin_gated), 32'(pin_raw));
		chk(32'({hresp, hreadyout}), 32'h1);
	endtask
	// reserved bits, all mux and hysteresis codes
	task automatic t_fields;
		bus(1'b1, CCS_ECON_OFS, 8'hff);
		rd(CCS_ECON_OFS, 32'h0000_003f);
		h = 3'h7;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h08, 8'(i));
			chk(32'(neg_sel[2]), 32'(i));
			if (i != 4) h = 3'(i);
			bus(1'b1, 8'h10, 8'(i));
			chk(32'(hyst[1]), 32'(h));
		end
	endtask
	// invert, pin drive, live status and flag write rules
	task automatic t_cond;
		bus(1'b1, CCS_ECON_OFS, 8'h00);
		bus(1'b1, CCS_STAT_OFS, 8'he0);
		bus(1'b1, CCS_ECON_OFS, 8'h30);
		tick(2);
		chk(32'({pin_oe[0], pin_out[0], live[0]}), 32'h7);
		rd(CCS_STAT_OFS, 32'h0000_0022);
		bus(1'b1, CCS_STAT_OFS, 8'h00);
		rd(CCS_STAT_OFS, 32'h0000_0022);
		bus(1'b1, CCS_STAT_OFS, 8'h20);
		rd(CCS_STAT_OFS, 32'h0000_0002);
		bus(1'b1, CCS_ECON_OFS, 8'h10);
		tick(2);
		chk(32'({pin_oe[0], pin_out[0], live[0]}), 32'h4);
		bus(1'b1, CCS_ECON_OFS, 8'h00);
		bus(1'b1, CCS_STAT_OFS, 8'he0);
	endtask
	// each sensitivity code against both edges
	task automatic t_sense;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 8'h04, 8'(s << 4));
			bus(1'b1, CCS_STAT_OFS, 8'he0);
			raw(1, 1'b1);
			chk(32'(flags[1]), 32'(s == 0 || s == 3));
			bus(1'b1, CCS_STAT_OFS, 8'he0);
			raw(1, 1'b0);
			chk(32'(flags[1]), 32'(s == 0 || s == 2));
		end
	endtask
	// enable gates the request and the vector's clear
	task automatic t_irq;
		bus(1'b1, 8'h04, 8'h00);
		raw(1, 1'b1);
		chk(32'({irq, irq_req[1]}), 32'h0);
		bus(1'b1, CCS_MASK_OFS, 8'h40);
		chk(32'({irq, irq_req[1]}), 32'h3);
		rd(CCS_MASK_OFS, 32'h0000_0040);
		ack1();
		chk(32'({irq, flags[1]}), 32'h0);
		bus(1'b1, CCS_MASK_OFS, 8'h00);
		raw(1, 1'b0);
		ack1();
		chk(32'(flags[1]), 32'h1);
	endtask
	// capture routing, edge select and timer mask
	task automatic t_cap;
		tim(1'b1, 1'b1);
		bus(1'b1, CCS_ECON_OFS, 8'h08);
		c0 = cap_count;
		raw(0, 1'b1);
		chk(cap_count - c0, 32'h1);
		raw(0, 1'b0);
		chk(cap_count - c0, 32'h1);
		tim(1'b0, 1'b1);
		raw(0, 1'b1);
		raw(0, 1'b0);
		chk(cap_count - c0, 32'h2);
		tim(1'b0, 1'b0);
		raw(0, 1'b1);
		raw(0, 1'b0);
		chk(cap_count - c0, 32'h2);
		tim(1'b0, 1'b1);
		bus(1'b1, CCS_ECON_OFS, 8'h00);
		raw(0, 1'b1);
		chk(32'(cap_input), 32'h0);
		raw(0, 1'b0);
		chk(cap_count - c0, 32'h2);
	endtask
	// input disable gates the port bits
	task automatic t_pins;
		bus(1'b1, CCS_DIS_LO_OFS, 8'ha5);
		bus(1'b1, CCS_DIS_HI_OFS, 8'h3c);
		rd(CCS_DIS_LO_OFS, 32'h0000_00a5);
		rd(CCS_DIS_HI_OFS, 32'h0000_003c);
		chk({pin_dis, pin_gated}, 32'h3ca5_c35a);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence, with a second reset in mid-run
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_fields();
		t_cond();
		t_sense();
		t_irq();
		t_cap();
		t_pins();
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		t_reset();
		results();
	end
	// hang guard
	initial begin
		#200000;
		n_fail++;
		results();
	end
endmodule

/* src/ccs_chan.sv */
// one comparator channel: output conditioning, event detect, sticky flag
// assumes the analog result is synchronous to clk
`timescale 1ns/100ps
module ccs_chan
	import ccs_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, high
	input wire logic raw_out, // analog core result
	input wire ccs_chan_cfg_t cfg, // channel settings
	input wire logic irq_en, // interrupt enable
	input wire logic vec_ack, // interrupt vector executed
	input wire logic flag_wr1, // software writes one
	output logic cond_out, // conditioned output
	output logic flag // sticky event flag
);
	logic prev_out;
	logic evt;

	// invert and register the comparator result
	always_ff @(posedge clk) begin
		if (srst) begin
			cond_out <= 1'b0;
			prev_out <= 1'b0;
		end else begin
			cond_out <= raw_out ^ cfg.invert; // R2
			prev_out <= cond_out;
		end
	end

	// event by sensitivity code, reserved code never fires
	always_comb begin
		case (cfg.sens)
			CCS_SENS_TOGGLE: evt = cond_out ^ prev_out; // R16
			CCS_SENS_FALL: evt = prev_out & ~cond_out; // R16
			CCS_SENS_RISE: evt = cond_out & ~prev_out; // R16
			default: evt = 1'b0;
		endcase
	end

	// set wins over both clears
	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (evt) begin
			flag <= 1'b1; // R9
		end else if (flag_wr1 || (vec_ack && irq_en)) begin
			flag <= 1'b0; // R10 R11
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	flag_set_a: assert property ( // R9
		evt |=> flag)
		else $error("event did not set flag");
	wone_clear_a: assert property ( // R11
		flag_wr1 && !evt |=> !flag)
		else $error("write one did not clear flag");
	ack_gate_a: assert property ( // R10
		vec_ack && !irq_en && !flag_wr1 && flag |=> flag)
		else $error("ack cleared flag while disabled");
	invert_out_a: assert property ( // R2
		1'b1 |=> cond_out == ($past(raw_out) ^ $past(cfg.invert)))
		else $error("output conditioning wrong");
	rise_only_a: assert property ( // R16
		cfg.sens == CCS_SENS_RISE && evt |-> cond_out && !prev_out)
		else $error("rising event without rising edge");
endmodule

/* src/ccs_comparator_regs.sv */
// comparator control and status register bank with an ahb-lite slave
// assumes single word transfers and synchronous comparator results
`timescale 1ns/100ps
module ccs_comparator_regs
	import ccs_pkg::*;
#(
	parameter int NUM_CMP = 3, // comparators served
	parameter int NUM_PINS = 16 // analog pins with input disable
) (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write transfer
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always okay
	input wire logic [NUM_CMP-1:0] cmp_raw, // analog results
	input wire logic [NUM_CMP-1:0] irq_ack, // vector executed
	input wire logic timer_capture_edge_select, // 1 rising
	input wire logic timer_capture_irq_mask, // capture irq on
	input wire logic [NUM_PINS-1:0] pin_raw, // pin input buffers
	output logic [NUM_CMP-1:0][2:0] cmp_neg_select, // neg mux
	output logic [NUM_CMP-1:0][2:0] cmp_hysteresis, // hysteresis
	output logic [NUM_CMP-1:0] cmp_pin_out, // output pin data
	output logic [NUM_CMP-1:0] cmp_pin_oe, // output pin drive
	output logic [NUM_CMP-1:0] cmp_live_output, // conditioned
	output logic [NUM_CMP-1:0] cmp_event_flag, // conv triggers
	output logic [NUM_CMP-1:0] cmp_irq_req, // per-cmp request
	output logic cap_input, // to timer capture front end
	output logic cap_event, // selected capture edge
	output logic cap_irq_req, // capture interrupt request
	output logic [NUM_PINS-1:0] pin_in_disable, // buffer off
	output logic [NUM_PINS-1:0] pin_in_gated, // port input bits
	output logic irq // combined interrupt
);
	if (NUM_CMP < 1 || NUM_CMP > 3) begin : g_chk_cmp
		$error("NUM_CMP must be 1 to 3");
	end
	if (NUM_PINS < 1 || NUM_PINS > 16) begin : g_chk_pins
		$error("NUM_PINS must be 1 to 16");
	end

	logic [7:0] ctrl [NUM_CMP];
	logic [7:0] econ [NUM_CMP];
	logic [NUM_CMP-1:0] irq_mask;
	logic [7:0] dis_lo;
	logic [7:0] dis_hi;
	logic [NUM_CMP-1:0] cond;
	logic [NUM_CMP-1:0] flags;
	logic [NUM_CMP-1:0] route;
	logic a_valid;
	logic a_write;
	logic [7:0] a_ofs;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] next_rdata;
	logic cap_prev;
	logic next_cap;
	logic [15:0] dis_all;

	// channel index of an offset inside a block of per-channel registers
	function automatic int chan_of(input logic [7:0] ofs,
		input logic [7:0] base);
		int idx;
		idx = -1;
		for (int i = 0; i < NUM_CMP; i++) begin
			if (ofs == base + 8'(i * 4)) begin
				idx = i;
			end
		end
		return idx;
	endfunction

	// address phase capture; hsize is not checked, word access assumed
	always_ff @(posedge clk) begin
		if (srst) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_ofs <= CCS_REG_RST;
		end else if (hready) begin
			a_valid <= hsel && htrans[CCS_HTRANS_ACT_BIT];
			a_write <= hwrite;
			a_ofs <= haddr[7:0];
		end
	end

	assign wr = a_valid && a_write;
	assign wdata = hwdata[7:0];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// per-comparator control: sensitivity and negative input select
	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_CMP; i++) begin
			if (srst) begin
				ctrl[i] <= CCS_REG_RST; // R18
			end else if (wr && chan_of(a_ofs, CCS_CTRL_OFS) == i) begin
				ctrl[i] <= wdata & CCS_CTRL_MASK; // R1 R18
			end
		end
	end

	// extended control; a reserved hysteresis code keeps the old one
	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_CMP; i++) begin
			if (srst) begin
				econ[i] <= CCS_REG_RST;
			end else if (wr && chan_of(a_ofs, CCS_ECON_OFS) == i) begin
				econ[i][7:3] <= wdata[7:3] & CCS_ECON_MASK[7:3];
				if (wdata[2:0] != CCS_HYST_RSVD) begin
					econ[i][2:0] <= wdata[2:0]; // R8
				end
			end
		end
	end

	// interrupt enables, laid out like the status flags
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_mask <= '0;
		end else if (wr && a_ofs == CCS_MASK_OFS) begin
			irq_mask <= wdata[CCS_FLAG_LSB +: NUM_CMP]; // R17
		end
	end

	// digital input disable registers
	always_ff @(posedge clk) begin
		if (srst) begin
			dis_lo <= CCS_REG_RST;
			dis_hi <= CCS_REG_RST;
		end else if (wr && a_ofs == CCS_DIS_LO_OFS) begin
			dis_lo <= wdata;
		end else if (wr && a_ofs == CCS_DIS_HI_OFS) begin
			dis_hi <= wdata;
		end
	end

	// one channel per comparator
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_chan
		ccs_chan_cfg_t cfg;
		logic wr1;
		assign cfg.invert = econ[g][CCS_INV_BIT];
		assign cfg.pin_en = econ[g][CCS_PIN_EN_BIT];
		assign cfg.route = econ[g][CCS_ROUTE_BIT];
		assign cfg.sens = ctrl[g][CCS_SENS_LSB +: 2];
		assign cfg.hyst = econ[g][CCS_HYST_LSB +: 3];
		assign wr1 = wr && a_ofs == CCS_STAT_OFS
			&& wdata[CCS_FLAG_LSB + g]; // R11
		ccs_chan u_chan (
			.clk(clk),
			.srst(srst),
			.raw_out(cmp_raw[g]),
			.cfg(cfg),
			.irq_en(irq_mask[g]),
			.vec_ack(irq_ack[g]), // R10
			.flag_wr1(wr1),
			.cond_out(cond[g]),
			.flag(flags[g])
		);
		assign route[g] = cfg.route;
		assign cmp_neg_select[g] = ctrl[g][CCS_NEG_LSB +: 3]; // R1
		assign cmp_hysteresis[g] = cfg.hyst; // R8
		assign cmp_pin_oe[g] = cfg.pin_en; // R3
		assign cmp_pin_out[g] = cfg.pin_en & cond[g]; // R3
	end

	// live outputs, triggers and interrupt requests
	assign cmp_live_output = cond; // R13
	assign cmp_event_flag = flags; // R12
	assign cmp_irq_req = flags & irq_mask; // R17
	assign irq = |(flags & irq_mask);

	// capture routing: only routed comparators reach the timer
	assign next_cap = |(route & cond); // R4 R6

	// capture level and edge toward the timer
	always_ff @(posedge clk) begin
		if (srst) begin
			cap_input <= 1'b0;
			cap_prev <= 1'b0;
		end else begin
			cap_input <= next_cap;
			cap_prev <= cap_input;
		end
	end

	// edge chosen by the timer edge select
	always_comb begin
		if (!(|route)) begin
			cap_event = 1'b0; // R6
		end else if (timer_capture_edge_select) begin
			cap_event = cap_input & ~cap_prev; // R5
		end else begin
			cap_event = cap_prev & ~cap_input; // R5
		end
	end
	assign cap_irq_req = cap_event & timer_capture_irq_mask; // R7

	// input disable gates pin inputs to zero
	assign dis_all = {dis_hi, dis_lo};
	assign pin_in_disable = dis_all[NUM_PINS-1:0]; // R14
	assign pin_in_gated = pin_raw & ~pin_in_disable; // R14

	// read mux in the address phase, unmapped reads zero
	always_comb begin
		int ci;
		int ei;
		ci = chan_of(haddr[7:0], CCS_CTRL_OFS);
		ei = chan_of(haddr[7:0], CCS_ECON_OFS);
		next_rdata = CCS_REG_RST;
		if (ci >= 0) begin
			next_rdata = ctrl[ci];
		end else if (ei >= 0) begin
			next_rdata = econ[ei];
		end else begin
			case (haddr[7:0])
				CCS_STAT_OFS: begin
					next_rdata[CCS_FLAG_LSB +: NUM_CMP] = flags;
					next_rdata[CCS_LIVE_LSB +: NUM_CMP] = cond; // R13
				end
				CCS_MASK_OFS: next_rdata[CCS_FLAG_LSB +: NUM_CMP] = irq_mask;
				CCS_DIS_LO_OFS: next_rdata = dis_lo;
				CCS_DIS_HI_OFS: next_rdata = dis_hi;
				default: next_rdata = CCS_REG_RST; // R18
			endcase
		end
	end

	// read data registered for the data phase
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[CCS_HTRANS_ACT_BIT]
			&& !hwrite) begin
			hrdata <= {24'h00_0000, next_rdata};
		end
	end

	// checks on the bus, the capture path and the pins
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	pin_drive_a: assert property ( // R3
		cmp_pin_oe[0] |-> cmp_pin_out[0] == cmp_live_output[0])
		else $error("enabled pin does not carry output");
	pin_off_a: assert property ( // R3
		!cmp_pin_oe[0] |-> !cmp_pin_out[0])
		else $error("disabled pin still driven");
	cap_off_a: assert property ( // R6
		route == '0 ##1 route == '0 |=> !cap_input && !cap_event)
		else $error("capture path active while unrouted");
	cap_rise_a: assert property ( // R5
		cap_event && timer_capture_edge_select |-> cap_input && !cap_prev)
		else $error("capture event not on rising edge");
	irq_line_a: assert property ( // R17
		irq == |(cmp_event_flag & irq_mask))
		else $error("interrupt line mismatch");
	pin_gate_a: assert property ( // R14
		(pin_in_gated & pin_in_disable) == '0)
		else $error("disabled pin input reads one");
	neg_write_a: assert property ( // R1
		wr && chan_of(a_ofs, CCS_CTRL_OFS) == NUM_CMP - 1
		|=> cmp_neg_select[NUM_CMP-1] == $past(wdata[2:0]))
		else $error("negative select not written");
	hyst_rsvd_a: assert property ( // R8
		wr && chan_of(a_ofs, CCS_ECON_OFS) >= 0
		&& wdata[2:0] == CCS_HYST_RSVD |=> $stable(cmp_hysteresis))
		else $error("reserved hysteresis code accepted");
	live_bits_a: assert property ( // R13
		hready && hsel && htrans[CCS_HTRANS_ACT_BIT] && !hwrite
		&& haddr[7:0] == CCS_STAT_OFS
		|=> hrdata[CCS_LIVE_LSB +: NUM_CMP] == $past(cmp_live_output))
		else $error("live output bits wrong");
	flag_bits_a: assert property ( // R9
		hready && hsel && htrans[CCS_HTRANS_ACT_BIT] && !hwrite
		&& haddr[7:0] == CCS_STAT_OFS
		|=> hrdata[CCS_FLAG_LSB +: NUM_CMP] == $past(cmp_event_flag))
		else $error("status flag bits wrong");
	stat_rsvd_a: assert property ( // R18
		hready && hsel && htrans[CCS_HTRANS_ACT_BIT] && !hwrite
		&& haddr[7:0] == CCS_STAT_OFS
		|=> !hrdata[CCS_FLAG_LSB-1] && !hrdata[CCS_LIVE_LSB-1]
			&& hrdata[31:8] == 24'h00_0000)
		else $error("reserved status bits not zero");
	cap_fall_a: assert property ( // R5
		cap_event && !timer_capture_edge_select |-> !cap_input && cap_prev)
		else $error("capture event not on falling edge");
	mask_write_a: assert property ( // R17
		wr && a_ofs == CCS_MASK_OFS
		|=> irq_mask == $past(wdata[CCS_FLAG_LSB +: NUM_CMP]))
		else $error("interrupt enables not written");
	dis_write_a: assert property ( // R14
		wr && a_ofs == CCS_DIS_LO_OFS |=> dis_lo == $past(wdata))
		else $error("input disable low not written");
	dis_high_a: assert property ( // R14
		wr && a_ofs == CCS_DIS_HI_OFS |=> dis_hi == $past(wdata))
		else $error("input disable high not written");
	pin_pass_a: assert property ( // R14
		(pin_in_gated | pin_in_disable) == (pin_raw | pin_in_disable))
		else $error("enabled pin input not passed");

	// per-comparator checks of pin, routing, requests and reserved bits
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_chk_chan
		pin_each_a: assert property (@(posedge clk) disable iff (srst) // R3
			cmp_pin_out[g] == (cmp_pin_oe[g] & cmp_live_output[g]))
			else $error("pin output does not follow enable");
		route_on_a: assert property (@(posedge clk) disable iff (srst) // R4
			route[g] && cmp_live_output[g] |=> cap_input)
			else $error("routed output did not reach capture");
		req_gate_a: assert property (@(posedge clk) disable iff (srst) // R17
			cmp_irq_req[g] == (cmp_event_flag[g] && irq_mask[g]))
			else $error("interrupt request not gated by enable");
		sens_rsvd_a: assert property (@(posedge clk) disable iff (srst) // R16
			ctrl[g][CCS_SENS_LSB +: 2] == CCS_SENS_RSVD
			&& !cmp_event_flag[g] |=> !cmp_event_flag[g])
			else $error("reserved sensitivity set a flag");
		ctrl_rsvd_a: assert property (@(posedge clk) disable iff (srst) // R18
			(ctrl[g] & ~CCS_CTRL_MASK) == 8'h00)
			else $error("reserved control bits set");
		econ_rsvd_a: assert property (@(posedge clk) disable iff (srst) // R18
			(econ[g] & ~CCS_ECON_MASK) == 8'h00)
			else $error("reserved extended bits set");
		hyst_write_a: assert property (@(posedge clk) disable iff (srst) // R8
			wr && chan_of(a_ofs, CCS_ECON_OFS) == g
			&& wdata[2:0] != CCS_HYST_RSVD
			|=> cmp_hysteresis[g] == $past(wdata[2:0]))
			else $error("hysteresis code not written");
		wone_top_a: assert property (@(posedge clk) disable iff (srst) // R11
			wr && a_ofs == CCS_STAT_OFS && !wdata[CCS_FLAG_LSB + g]
			&& cmp_event_flag[g] && !(irq_ack[g] && irq_mask[g])
			|=> cmp_event_flag[g])
			else $error("writing zero cleared a flag");
		live_each_a: assert property (@(posedge clk) disable iff (srst) // R2
			1'b1 |=> cmp_live_output[g]
				== ($past(cmp_raw[g]) ^ $past(econ[g][CCS_INV_BIT])))
			else $error("live output not conditioned");
		flag_hold_a: assert property (@(posedge clk) disable iff (srst) // R9
			cmp_event_flag[g] && !irq_ack[g]
			&& !(wr && a_ofs == CCS_STAT_OFS)
			|=> cmp_event_flag[g])
			else $error("event flag dropped without a clear");
	end
endmodule

/* src/ccs_pkg.sv */
// constants, field layout and carrier types of the comparator register bank
// assumes one 50 MHz clock, synchronous reset and an AHB-Lite master
// Functional notes
// R1: select comparator three negative input source
// R2: invert bit flips comparator output
// R3: pin enable connects output to pin
// R4: route bit feeds output to capture
// R5: capture edge follows timer edge select
// R6: route clear disconnects capture path fully
// R7: timer capture interrupt also needs mask
// R8: hysteresis code select, code four reserved
// R9: output event sets comparator event flag
// R10: vector ack clears flag when enabled
// R11: writing one clears flag, zero keeps
// R12: event flags exported as conversion triggers
// R13: status bits show live comparator outputs
// R14: input disable gates pin input zero
// R15: software disables unused analog pin inputs
// R16: sensitivity: toggle, falling, rising, one reserved
// R17: interrupt enable gates flag request
// R18: reserved bits zero, registers reset zero
package ccs_pkg;
	// register byte offsets
	localparam logic [7:0] CCS_CTRL_OFS = 8'h00;
	localparam logic [7:0] CCS_ECON_OFS = 8'h0c;
	localparam logic [7:0] CCS_STAT_OFS = 8'h18;
	localparam logic [7:0] CCS_MASK_OFS = 8'h1c;
	localparam logic [7:0] CCS_DIS_LO_OFS = 8'h20;
	localparam logic [7:0] CCS_DIS_HI_OFS = 8'h24;
	localparam logic [7:0] CCS_REG_STEP = 8'h04;
	// field positions
	localparam int CCS_NEG_LSB = 0;
	localparam int CCS_SENS_LSB = 4;
	localparam int CCS_HYST_LSB = 0;
	localparam int CCS_ROUTE_BIT = 3;
	localparam int CCS_PIN_EN_BIT = 4;
	localparam int CCS_INV_BIT = 5;
	localparam int CCS_FLAG_LSB = 5;
	localparam int CCS_LIVE_LSB = 1;
	// writable bits and reset values
	localparam logic [7:0] CCS_CTRL_MASK = 8'h37;
	localparam logic [7:0] CCS_ECON_MASK = 8'h3f;
	localparam logic [7:0] CCS_REG_RST = 8'h00;
	// sensitivity codes
	localparam logic [1:0] CCS_SENS_TOGGLE = 2'h0;
	localparam logic [1:0] CCS_SENS_RSVD = 2'h1;
	localparam logic [1:0] CCS_SENS_FALL = 2'h2;
	localparam logic [1:0] CCS_SENS_RISE = 2'h3;
	// hysteresis codes: 1..3 at 10 mV, 5..7 at 25 mV
	localparam logic [2:0] CCS_HYST_NONE = 3'h0;
	localparam logic [2:0] CCS_HYST_RSVD = 3'h4;
	// negative input codes: 0..3 vref fractions 6.40 down to 1.60
	localparam logic [2:0] CCS_NEG_VREF_640 = 3'h0;
	localparam logic [2:0] CCS_NEG_BANDGAP = 3'h4;
	localparam logic [2:0] CCS_NEG_DAC = 3'h5;
	localparam logic [2:0] CCS_NEG_OWN_PIN = 3'h6;
	localparam logic [2:0] CCS_NEG_SHARED_PIN = 3'h7;
	// ahb transfer type bit that marks an active transfer
	localparam int CCS_HTRANS_ACT_BIT = 1;

	// per-comparator settings handed to a channel
	typedef struct packed {
		logic invert;
		logic pin_en;
		logic route;
		logic [1:0] sens;
		logic [2:0] hyst;
	} ccs_chan_cfg_t;
endpackage
